/* pkg/wws_pkg.sv */
// constants, states and state record of the window watchdog supervisor
package wws_pkg;

    // system clock rate
    localparam int unsigned CLK_MHZ = 25;

    // base tick of the internal timebase, in microseconds
    localparam int unsigned TICK_US = 500;
    localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
    localparam int unsigned TICK_W = 14;

    // width of the tick-based timers
    localparam int unsigned TMR_W = 8;

    // reset delay, the same for both timebases
    localparam int unsigned TRD_MS = 8;
    localparam logic [TMR_W-1:0] TRD_TICKS = TMR_W'(TRD_MS * 1000 / TICK_US);

    // sampling interval, fast and slow
    localparam int unsigned SAM_FAST_US = 500;
    localparam int unsigned SAM_SLOW_US = 1000;
    localparam logic [TMR_W-1:0] SAM_FAST_T = TMR_W'(SAM_FAST_US / TICK_US);
    localparam logic [TMR_W-1:0] SAM_SLOW_T = TMR_W'(SAM_SLOW_US / TICK_US);

    // holdoff window, fast and slow
    localparam int unsigned IW_FAST_US = 32000;
    localparam int unsigned IW_SLOW_US = 64000;
    localparam logic [TMR_W-1:0] IW_FAST_T = TMR_W'(IW_FAST_US / TICK_US);
    localparam logic [TMR_W-1:0] IW_SLOW_T = TMR_W'(IW_SLOW_US / TICK_US);

    // trigger period, fast and slow
    localparam int unsigned WDP_FAST_US = 32000;
    localparam int unsigned WDP_SLOW_US = 64000;
    localparam logic [TMR_W-1:0] WDP_FAST_T = TMR_W'(WDP_FAST_US / TICK_US);
    localparam logic [TMR_W-1:0] WDP_SLOW_T = TMR_W'(WDP_SLOW_US / TICK_US);

    // sample history: high, high, low, low, oldest in the top bit
    localparam logic [3:0] HIST_VALID = 4'hc;
    localparam logic [3:0] HIST_CLR = 4'h0;

    // supervisor states
    typedef enum logic [2:0] {
        ST_RST = 3'h0,
        ST_HOLD = 3'h1,
        ST_IGN = 3'h2,
        ST_WIN = 3'h3,
        ST_GAP = 3'h4
    } wws_state_t;

    // whole state of the supervisor
    typedef struct packed {
        logic ro_m;
        logic ro_s;
        logic trig_m;
        logic trig_s;
        logic sel_m;
        logic sel_s;
        wws_state_t st;
        logic [TICK_W-1:0] tick;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] samp;
        logic [3:0] hist;
        logic slow;
        logic fault_n;
        logic fault_oe;
    } wws_reg_t;

endpackage

/* logic/wws_supervisor.sv */
// window watchdog supervisor: trigger sampling, windows and fault output
`timescale 1ns/100ps
`default_nettype none

module wws_supervisor #(
    parameter int unsigned TICK_CYC = wws_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // pins from the reset generator and the processor
    input wire logic reset_output_n_i,
    input wire logic wd_trigger_in_i,
    input wire logic timebase_select_i,
    // open-drain fault pin
    output logic wd_fault_out_n_o,
    output logic wd_fault_oe_o
);

    wws_pkg::wws_reg_t q;
    wws_pkg::wws_reg_t d;
    logic tick_ev;
    logic samp_ev;
    logic trig_ok;
    logic [wws_pkg::TMR_W-1:0] tmr_nx;
    logic [wws_pkg::TMR_W-1:0] samp_nx;

    // picks the fast or slow figure of a timing value
    function automatic logic [wws_pkg::TMR_W-1:0] pick_t(
        input logic slow,
        input logic [wws_pkg::TMR_W-1:0] fast_v,
        input logic [wws_pkg::TMR_W-1:0] slow_v
    );
        pick_t = slow ? slow_v : fast_v;
    endfunction

    // sampling interval of the latched timebase
    function automatic logic [wws_pkg::TMR_W-1:0] sam_t(input logic slow);
        sam_t = pick_t(slow, wws_pkg::SAM_FAST_T, wws_pkg::SAM_SLOW_T);
    endfunction

    // base tick, tick timer and sample strobe
    always_comb begin
        tick_ev = (q.tick == wws_pkg::TICK_W'(TICK_CYC - 1));
        tmr_nx = q.tmr + 1'b1;
        samp_nx = q.samp + 1'b1;
        samp_ev = tick_ev && (samp_nx >= sam_t(q.slow));
        trig_ok = (q.st == wws_pkg::ST_WIN) && (q.hist == wws_pkg::HIST_VALID);
    end

    // next state of the whole supervisor
    always_comb begin
        d = q;
        // two-stage synchronisers for the pins
        d.ro_m = reset_output_n_i;
        d.ro_s = q.ro_m;
        d.trig_m = wd_trigger_in_i;
        d.trig_s = q.trig_m;
        d.sel_m = timebase_select_i;
        d.sel_s = q.sel_m;
        // wrapping tick and tick-based timer, both restarted on state entry
        d.tick = tick_ev ? '0 : q.tick + 1'b1;
        if (tick_ev) begin
            d.tmr = tmr_nx;
        end
        // periodic sampling into the history
        if (samp_ev) begin
            d.samp = '0;
            d.hist = {q.hist[2:0], q.trig_s};
        end else if (tick_ev) begin
            d.samp = samp_nx;
        end
        case (q.st)
            wws_pkg::ST_RST: begin
                d.fault_n = 1'b0;
                if (q.ro_s) begin
                    d.st = wws_pkg::ST_HOLD;
                end
            end
            wws_pkg::ST_HOLD: begin
                d.fault_n = 1'b0;
                if (tick_ev && tmr_nx >= wws_pkg::TRD_TICKS) begin
                    d.st = wws_pkg::ST_IGN;
                    d.fault_n = 1'b1;
                    d.slow = q.sel_s;
                end
            end
            wws_pkg::ST_IGN: begin
                // history held clear, so nothing seen here can count later
                d.hist = wws_pkg::HIST_CLR;
                if (tick_ev && tmr_nx >= pick_t(q.slow, wws_pkg::IW_FAST_T,
                        wws_pkg::IW_SLOW_T)) begin
                    d.st = wws_pkg::ST_WIN;
                    d.slow = q.sel_s;
                end
            end
            wws_pkg::ST_WIN: begin
                if (trig_ok) begin
                    d.st = wws_pkg::ST_GAP;
                    d.hist = wws_pkg::HIST_CLR;
                end else if (tick_ev && tmr_nx >= pick_t(q.slow, wws_pkg::WDP_FAST_T,
                        wws_pkg::WDP_SLOW_T) - sam_t(q.slow)) begin
                    d.st = wws_pkg::ST_HOLD;
                    d.fault_n = 1'b0;
                end
            end
            wws_pkg::ST_GAP: begin
                if (tick_ev && tmr_nx >= sam_t(q.slow)) begin
                    d.st = wws_pkg::ST_WIN;
                    d.slow = q.sel_s;
                end
            end
            default: begin
                d.st = wws_pkg::ST_RST;
                d.fault_n = 1'b0;
            end
        endcase
        // a low reset output overrides everything
        if (!q.ro_s) begin
            d.st = wws_pkg::ST_RST;
            d.fault_n = 1'b0;
        end
        // every state entry restarts the timebase
        if (d.st != q.st) begin
            d.tick = '0;
            d.tmr = '0;
            d.samp = '0;
        end
        d.fault_oe = ~d.fault_n;
    end

    // state register
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q.ro_m <= 1'b0;
            q.ro_s <= 1'b0;
            q.trig_m <= 1'b0;
            q.trig_s <= 1'b0;
            q.sel_m <= 1'b0;
            q.sel_s <= 1'b0;
            q.st <= wws_pkg::ST_RST;
            q.tick <= '0;
            q.tmr <= '0;
            q.samp <= '0;
            q.hist <= wws_pkg::HIST_CLR;
            q.slow <= 1'b0;
            q.fault_n <= 1'b0;
            q.fault_oe <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // fault pin; the reset output is only read, never driven
    assign wd_fault_out_n_o = q.fault_n;
    assign wd_fault_oe_o = q.fault_oe;

    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_hold_end;
        (q.st == wws_pkg::ST_HOLD) ##1 (q.st == wws_pkg::ST_IGN);
    endsequence

    sequence s_trig_taken;
        trig_ok ##1 (q.st == wws_pkg::ST_GAP);
    endsequence

    property p_reset_forces_fault;
        !q.ro_s |=> !wd_fault_out_n_o && (q.st == wws_pkg::ST_RST);
    endproperty
    a_reset_forces_fault: assert property (p_reset_forces_fault)
        else $error("fault output not low while reset output low");

    property p_release_to_hold;
        (q.st == wws_pkg::ST_RST && q.ro_s) |=> (q.st == wws_pkg::ST_HOLD) && !wd_fault_out_n_o;
    endproperty
    a_release_to_hold: assert property (p_release_to_hold)
        else $error("reset release did not start the reset delay");

    property p_hold_bounded;
        (q.st == wws_pkg::ST_HOLD) |-> (q.tmr < wws_pkg::TRD_TICKS) && !wd_fault_out_n_o;
    endproperty
    a_hold_bounded: assert property (p_hold_bounded)
        else $error("reset delay overran or fault high during it");

    property p_fault_rise_ign;
        $rose(wd_fault_out_n_o) |-> (q.st == wws_pkg::ST_IGN) && $past(q.tmr) ==
            wws_pkg::TRD_TICKS - 1'b1;
    endproperty
    a_fault_rise_ign: assert property (p_fault_rise_ign)
        else $error("fault released without full reset delay");

    property p_hold_releases;
        s_hold_end |-> wd_fault_out_n_o;
    endproperty
    a_hold_releases: assert property (p_hold_releases)
        else $error("holdoff opened with fault output low");

    property p_trig_ends_window;
        s_trig_taken |-> q.tmr == '0 ##1 (q.st != wws_pkg::ST_HOLD);
    endproperty
    a_trig_ends_window: assert property (p_trig_ends_window)
        else $error("valid trigger did not end the window");

    property p_window_miss;
        ($past(q.st) == wws_pkg::ST_WIN && q.st == wws_pkg::ST_HOLD) |-> !wd_fault_out_n_o
            && !$past(trig_ok);
    endproperty
    a_window_miss: assert property (p_window_miss)
        else $error("window closed without pulling fault low");

    property p_ignore_blind;
        (q.st == wws_pkg::ST_IGN) |=> (q.st != wws_pkg::ST_GAP) && (q.st != wws_pkg::ST_HOLD);
    endproperty
    a_ignore_blind: assert property (p_ignore_blind)
        else $error("trigger acted on during holdoff window");

    property p_timebase_latch;
        $changed(q.slow) |-> (q.st == wws_pkg::ST_WIN || q.st == wws_pkg::ST_IGN)
            && $past(q.st) != q.st;
    endproperty
    a_timebase_latch: assert property (p_timebase_latch)
        else $error("timebase changed inside a period");

    property p_sample_on_tick;
        samp_ev |-> tick_ev && (q.samp == sam_t(q.slow) - 1'b1);
    endproperty
    a_sample_on_tick: assert property (p_sample_on_tick)
        else $error("sample taken off the sampling interval");

    property p_pin_drive;
        wd_fault_oe_o == !wd_fault_out_n_o;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("fault pin enable disagrees with level");

    property p_select_latch;
        s_hold_end |-> q.slow == $past(q.sel_s);
    endproperty
    a_select_latch: assert property (p_select_latch)
        else $error("holdoff did not take the selected timebase");

    property p_ignore_clears;
        (q.st == wws_pkg::ST_IGN) |=> (q.hist == wws_pkg::HIST_CLR) && !trig_ok;
    endproperty
    a_ignore_clears: assert property (p_ignore_clears)
        else $error("trigger history kept during holdoff window");

    property p_ignore_len;
        (q.st == wws_pkg::ST_IGN) |-> q.tmr < pick_t(q.slow, wws_pkg::IW_FAST_T,
            wws_pkg::IW_SLOW_T);
    endproperty
    a_ignore_len: assert property (p_ignore_len)
        else $error("holdoff window overran its length");

    property p_window_len;
        (q.st == wws_pkg::ST_WIN) |-> q.tmr < pick_t(q.slow, wws_pkg::WDP_FAST_T,
            wws_pkg::WDP_SLOW_T) - sam_t(q.slow);
    endproperty
    a_window_len: assert property (p_window_len)
        else $error("trigger window overran period minus one sample");

    property p_gap_len;
        (q.st == wws_pkg::ST_GAP) |-> (q.tmr < sam_t(q.slow)) && wd_fault_out_n_o;
    endproperty
    a_gap_len: assert property (p_gap_len)
        else $error("gap after trigger overran one sample");

    property p_trig_pattern;
        ($past(q.st) == wws_pkg::ST_WIN && q.st == wws_pkg::ST_GAP) |-> $past(q.hist) ==
            wws_pkg::HIST_VALID;
    endproperty
    a_trig_pattern: assert property (p_trig_pattern)
        else $error("trigger taken without two highs then two lows");

    property p_late_low;
        (q.st == wws_pkg::ST_HOLD) |=> (q.st != wws_pkg::ST_GAP) && (q.st != wws_pkg::ST_WIN);
    endproperty
    a_late_low: assert property (p_late_low)
        else $error("late trigger sample accepted after window closed");

endmodule

`default_nettype wire

/* sim/wws_cpu_model.sv */
// behavioural processor that pulses the watchdog trigger pin
`timescale 1ns/100ps
`default_nettype none

module wws_cpu_model (
    // clock
    input wire logic clk_i,
    // trigger control from the bench
    input wire logic en_i,
    input wire logic [7:0] hi_cyc_i,
    input wire logic [7:0] per_cyc_i,
    // trigger pin
    output logic trig_o
);
    logic [7:0] cnt_q;

    // period counter, parked at zero while idle
    always_ff @(posedge clk_i) begin
        if (!en_i || cnt_q >= per_cyc_i - 8'h01) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // high at period start, then low; idle pin sits at its pull-down level
    assign trig_o = en_i && (cnt_q < hi_cyc_i);
endmodule
`default_nettype wire

/* sim/wws_supervisor_tb.sv */
// self-checking bench of the window watchdog supervisor
`timescale 1ns/100ps
`default_nettype none

module wws_supervisor_tb;
    localparam int TRD = 64;
    logic sys_clk_i;
    logic rst_b_i;
    logic reset_output_n_i;
    logic timebase_select_i;
    logic cpu_en;
    logic [7:0] cpu_hi;
    logic trig;
    logic fault_n;
    logic fault_oe;
    int error_cnt;
    int checks;
    int n;

    // processor on the trigger pin
    wws_cpu_model i_cpu (.clk_i(sys_clk_i), .en_i(cpu_en), .hi_cyc_i(cpu_hi),
        .per_cyc_i(8'ha0), .trig_o(trig));

    // block under test with a short tick
    wws_supervisor #(.TICK_CYC(4)) i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .reset_output_n_i(reset_output_n_i), .wd_trigger_in_i(trig),
        .timebase_select_i(timebase_select_i), .wd_fault_out_n_o(fault_n),
        .wd_fault_oe_o(fault_oe));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk_range(input int v, input int lo, input int hi);
        check({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
    endtask

    // cycles until the fault level reaches lvl, sampled mid-cycle
    task automatic wait_fault(input logic lvl, input int max, output int cnt);
        cnt = 0;
        while (fault_n !== lvl && cnt < max) begin
            @(negedge sys_clk_i);
            cnt++;
        end
        check({30'h0, fault_oe, fault_n}, {30'h0, ~lvl, lvl});
    endtask

    // cycles within a span where the fault level was not lvl
    task automatic count_off(input logic lvl, input int span, output int cnt);
        cnt = 0;
        repeat (span) begin
            @(negedge sys_clk_i);
            if (fault_n !== lvl) cnt++;
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic t_release();
        @(posedge sys_clk_i);
        reset_output_n_i <= 1'b1;
        wait_fault(1'b1, 200, n);
        chk_range(n, TRD, TRD + 8);
    endtask

    task automatic t_power_up();
        repeat (10) @(negedge sys_clk_i);
        check({31'h0, fault_n}, 32'h0);
        t_release();
    endtask

    // no trigger: fault falls after holdoff plus window, then rises after the reset delay
    task automatic t_missed(input int exp);
        wait_fault(1'b0, 2000, n);
        chk_range(n, exp - 8, exp + 8);
        wait_fault(1'b1, 200, n);
        chk_range(n, TRD - 2, TRD + 4);
    endtask

    // well formed triggers keep the fault high, across a timebase change
    task automatic t_good_switch();
        @(posedge sys_clk_i);
        cpu_hi <= 8'h18;
        cpu_en <= 1'b1;
        count_off(1'b1, 3000, n);
        check(n, 0);
        @(posedge sys_clk_i);
        timebase_select_i <= 1'b0;
        count_off(1'b1, 2000, n);
        check(n, 0);
        @(posedge sys_clk_i);
        cpu_en <= 1'b0;
        wait_fault(1'b0, 700, n);
        chk_range(n, 80, 270);
        wait_fault(1'b1, 200, n);
        chk_range(n, TRD - 2, TRD + 4);
    endtask

    // a pulse shorter than one sample is no trigger
    task automatic t_glitch();
        @(posedge sys_clk_i);
        cpu_hi <= 8'h02;
        cpu_en <= 1'b1;
        wait_fault(1'b0, 2000, n);
        chk_range(n, 500, 520);
        wait_fault(1'b1, 200, n);
        chk_range(n, TRD - 2, TRD + 4);
        @(posedge sys_clk_i);
        cpu_hi <= 8'h18;
    endtask

    // reset in mid-run forces the fault low until release plus delay
    task automatic t_reset_mid();
        count_off(1'b1, 900, n);
        check(n, 0);
        @(posedge sys_clk_i);
        reset_output_n_i <= 1'b0;
        wait_fault(1'b0, 8, n);
        chk_range(n, 0, 6);
        count_off(1'b0, 100, n);
        check(n, 0);
        t_release();
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt++;
        $display("ERROR at %0t: run did not finish", $time);
        summarize();
    end

    initial begin
        error_cnt = 0;
        checks = 0;
        rst_b_i = 1'b0;
        reset_output_n_i = 1'b0;
        timebase_select_i = 1'b0;
        cpu_en = 1'b0;
        cpu_hi = 8'h18;
        repeat (5) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        t_power_up();
        t_missed(508);
        @(posedge sys_clk_i);
        timebase_select_i <= 1'b1;
        t_missed(760);
        t_missed(1016);
        t_good_switch();
        t_glitch();
        t_reset_mid();
        summarize();
    end
endmodule
`default_nettype wire
